// ===== common/tunnel_defs.svh
// timing, character codes and field constants of the serial tunnel parser
`ifndef TUNNEL_DEFS_SVH
`define TUNNEL_DEFS_SVH
`define CH_CR 8'h0D
`define CH_BELL 8'h07
`define CH_SP 8'h20
`define CH_TILDE 8'h7E
`define CH_S 8'h53
`define CH_O 8'h4F
`define CH_L 8'h4C
`define CH_LL 8'h6C
`define CH_C 8'h43
`define CH_M 8'h4D
`define CH_LM 8'h6D
`define CH_T 8'h54
`define CH_LT 8'h74
`define CH_R 8'h52
`define CH_LR 8'h72
`define CH_Z 8'h5A
`define CH_LZ 8'h7A
`define EXT_ID_DIGITS 4'h8
`define STD_ID_DIGITS 4'h3
`define MAX_DLC 4'h8
`define RATE_RESET 32'h0007_A120
`endif

// ===== common/tunnel_pkg.sv
// types shared by the serial tunnel command parser
package tunnel_pkg;
	typedef enum logic [1:0] {
		CH_CLOSED = 2'b00,
		CH_NORMAL = 2'b01,
		CH_SILENT = 2'b10,
		CH_LOOP = 2'b11
	} chan_mode_t;
	typedef enum logic [2:0] {
		PS_ID = 3'b000,
		PS_ARG = 3'b001,
		PS_SKIP = 3'b010,
		PS_RESP = 3'b011,
		PS_ACK = 3'b100,
		PS_NOTE = 3'b101
	} parse_state_t;
endpackage

// ===== rtl/tunnel_cmd.sv
// command interpreter and responder for the ascii can tunnel protocol
// Notes on behaviour
// - blocks hold only printable ascii plus one terminator.
// - carriage return ends a block as ack, bell as nack.
// - first character of a block selects its kind.
// - each host command gets exactly one response block.
// - commands and notifications always end with carriage return.
// - response ends with cr on success, bell on failure or unknown.
// - handler serves usb while a host is present, uart otherwise.
// - a changed bit rate goes to nonvolatile store, restored at power-up.
// - decimal bit-rate argument is stored; open channel uses it on reopen.
// - arguments 0..8 map to the rate table, others taken literally.
// - O opens normal mode with stored rate, reopening if open.
// - L opens listen-only mode with stored rate, reopening if open.
// - l opens normal mode with loopback, reopening if open.
// - C closes the channel; nothing happens when already closed.
// - M and m ignore printable arguments and answer success; an unprintable argument byte answers bell.
// - in listen-only mode the controller never drives the bus.
// - in listen-only mode host frames are dropped, reception continues.
// - with loopback, delivered frames return to host as notifications.
// - with flags on, loopback notifications carry a loopback flag.
// - hex digits accepted in upper case, lower case and decimal.
// - T has 8 id digits, t has 3, then dlc and payload bytes.
// - R and r hold only id digits and dlc, no payload.
// - opening flushes all buffers and resets statistics.
// - controller stays disabled after start-up until opened.
// - a frame dropped on a full transmit queue still answers success.
`include "tunnel_defs.svh"
module tunnel_cmd import tunnel_pkg::*; (
	input wire logic clk, // system clock
	input wire logic arst_n, // asynchronous reset
	input wire logic usb_host_present, // usb host connected
	input wire logic [7:0] usb_rx_data, // byte from usb serial
	input wire logic usb_rx_valid, // usb byte strobe
	input wire logic [7:0] uart_rx_data, // byte from uart
	input wire logic uart_rx_valid, // uart byte strobe
	input wire logic tx_ready, // serial sender takes a byte
	input wire logic flags_on, // frame flags enabled setting
	input wire logic [31:0] nv_rate, // stored bit rate at power-up
	input wire logic nv_rate_valid, // stored rate is valid
	input wire logic loop_done, // controller delivered a frame
	input wire logic loop_ext, // delivered frame has 29-bit id
	output logic [7:0] usb_tx_data, // byte to usb serial
	output logic usb_tx_valid, // usb byte strobe
	output logic [7:0] uart_tx_data, // byte to uart
	output logic uart_tx_valid, // uart byte strobe
	output logic can_enable, // controller enabled
	output logic can_silent, // controller never drives bus
	output logic can_loopback, // loopback notifications on
	output logic [31:0] can_rate, // rate applied at open
	output logic flush, // one-cycle buffer and counter clear
	output logic [28:0] frame_id, // frame identifier
	output logic frame_ext, // 29-bit identifier
	output logic frame_rtr, // remote frame
	output logic [3:0] frame_dlc, // data length code
	output logic [63:0] frame_data, // payload, first byte high
	output logic frame_valid, // one-cycle frame to queue
	output logic [31:0] nv_wr_rate, // rate to nonvolatile store
	output logic nv_wr // one-cycle store strobe
);
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic is_hex(input logic [7:0] c);
		return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46) ||
			(c >= 8'h61 && c <= 8'h66);
	endfunction
	function automatic logic [3:0] hex_val(input logic [7:0] c);
		if (c <= 8'h39)
			return c[3:0];
		return 4'(c[3:0] + 4'h9);
	endfunction
	function automatic logic [31:0] rate_map(input logic [31:0] v);
		unique case (v)
			32'h0: return 32'd10000;
			32'h1: return 32'd20000;
			32'h2: return 32'd50000;
			32'h3: return 32'd100000;
			32'h4: return 32'd125000;
			32'h5: return 32'd250000;
			32'h6: return 32'd500000;
			32'h7: return 32'd800000;
			32'h8: return 32'd1000000;
			default: return v;
		endcase
	endfunction
	// ****************************************
	// link selection
	// ****************************************
	logic [7:0] rx_byte;
	logic rx_strobe;
	logic [7:0] out_byte;
	logic out_go;
	// rx from the unused port is dropped, never merged
	always_comb begin
		rx_byte = usb_host_present ? usb_rx_data : uart_rx_data;
		rx_strobe = usb_host_present ? usb_rx_valid : uart_rx_valid;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			usb_tx_data <= 8'h00;
			usb_tx_valid <= 1'b0;
			uart_tx_data <= 8'h00;
			uart_tx_valid <= 1'b0;
		end else begin
			usb_tx_data <= out_byte;
			uart_tx_data <= out_byte;
			usb_tx_valid <= out_go && usb_host_present;
			uart_tx_valid <= out_go && !usb_host_present;
		end
	end
	// ****************************************
	// parser
	// ****************************************
	parse_state_t st_reg;
	logic [7:0] cmd_reg;
	logic [4:0] cnt_reg;
	logic bad_reg;
	logic [31:0] dec_reg;
	logic [28:0] id_reg;
	logic [3:0] dlc_reg;
	logic [63:0] pay_reg;
	logic ok_reg;
	logic loop_pend_reg;
	logic loop_ext_reg;
	logic [1:0] note_idx_reg;
	chan_mode_t mode_reg;
	logic [31:0] rate_reg;
	logic is_frame, ext, rtr;
	logic [4:0] id_n, need;
	logic printable;
	always_comb begin
		is_frame = cmd_reg == `CH_T || cmd_reg == `CH_LT ||
			cmd_reg == `CH_R || cmd_reg == `CH_LR;
		ext = cmd_reg == `CH_T || cmd_reg == `CH_R;
		rtr = cmd_reg == `CH_R || cmd_reg == `CH_LR;
		id_n = 5'(ext ? `EXT_ID_DIGITS : `STD_ID_DIGITS);
		// digits needed: id, dlc, then two per byte for data frames
		need = 5'(id_n + 5'd1 + (rtr ? 5'd0 : 5'({dlc_reg, 1'b0})));
		printable = rx_byte >= `CH_SP && rx_byte <= `CH_TILDE;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= PS_ID;
			cmd_reg <= 8'h00;
			cnt_reg <= 5'h00;
			bad_reg <= 1'b0;
			dec_reg <= 32'h0;
			id_reg <= 29'h0;
			dlc_reg <= 4'h0;
			pay_reg <= 64'h0;
			ok_reg <= 1'b0;
		end else if (st_reg == PS_ID && rx_strobe) begin
			if (rx_byte != `CH_CR) begin
				cmd_reg <= rx_byte;
				cnt_reg <= 5'h00;
				bad_reg <= !printable;
				dec_reg <= 32'h0;
				id_reg <= 29'h0;
				dlc_reg <= 4'h0;
				pay_reg <= 64'h0;
				st_reg <= PS_ARG;
			end
		end else if (st_reg == PS_ARG && rx_strobe) begin
			if (rx_byte == `CH_CR) begin
				st_reg <= PS_RESP;
			end else if (!printable) begin
				bad_reg <= 1'b1;
			end else if (is_frame) begin
				if (!is_hex(rx_byte) || cnt_reg >= need ||
					(cnt_reg == id_n && hex_val(rx_byte) > `MAX_DLC))
					bad_reg <= 1'b1;
				else if (cnt_reg < id_n)
					id_reg <= 29'({id_reg, hex_val(rx_byte)});
				else if (cnt_reg == id_n)
					dlc_reg <= hex_val(rx_byte);
				else
					pay_reg <= {pay_reg[59:0], hex_val(rx_byte)};
				if (cnt_reg != 5'h1F)
					cnt_reg <= 5'(cnt_reg + 5'd1);
			end else if (cmd_reg == `CH_S) begin
				if (rx_byte < 8'h30 || rx_byte > 8'h39)
					bad_reg <= 1'b1;
				else
					dec_reg <= 32'(dec_reg * 32'd10 + 32'(rx_byte[3:0]));
			end else if (cmd_reg != `CH_M && cmd_reg != `CH_LM) begin
				bad_reg <= 1'b1;
			end
		end else if (st_reg == PS_RESP) begin
			// accepted frame commands answer z/Z then cr; others only the terminator
			ok_reg <= !bad_reg;
			unique case (cmd_reg)
				`CH_S, `CH_O, `CH_L, `CH_LL, `CH_C, `CH_M, `CH_LM: ;
				`CH_T, `CH_LT, `CH_R, `CH_LR:
					if (bad_reg || cnt_reg != need || mode_reg == CH_CLOSED)
						ok_reg <= 1'b0;
				default: ok_reg <= 1'b0;
			endcase
			st_reg <= PS_ACK;
		end else if (st_reg == PS_ACK && tx_ready) begin
			if (!(ok_reg && is_frame) || cnt_reg == 5'h1F) begin
				st_reg <= PS_ID;
			end else begin
				cnt_reg <= 5'h1F;
			end
		end else if (st_reg == PS_SKIP) begin
			st_reg <= PS_ID;
		end else if (st_reg == PS_ID && loop_pend_reg && tx_ready) begin
			st_reg <= PS_NOTE;
		end else if (st_reg == PS_NOTE && tx_ready && note_idx_reg == 2'd3) begin
			st_reg <= PS_ID;
		end
	end
	// ****************************************
	// output byte sequencing
	// ****************************************
	// notification here carries the block kind, optional flag and cr only;
	// full frame text is rendered by the receive path elsewhere
	always_comb begin
		out_byte = `CH_CR;
		out_go = 1'b0;
		if (st_reg == PS_ACK && tx_ready) begin
			out_go = 1'b1;
			if (!ok_reg)
				out_byte = `CH_BELL;
			else if (is_frame && cnt_reg != 5'h1F)
				out_byte = ext ? `CH_Z : `CH_LZ;
			else
				out_byte = `CH_CR;
		end else if (st_reg == PS_NOTE && tx_ready) begin
			out_go = note_idx_reg != 2'd1 || flags_on;
			unique case (note_idx_reg)
				2'd0: out_byte = loop_ext_reg ? `CH_T : `CH_LT;
				2'd1: out_byte = `CH_LL;
				2'd2: out_go = 1'b0;
				2'd3: out_byte = `CH_CR;
			endcase
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			loop_pend_reg <= 1'b0;
			loop_ext_reg <= 1'b0;
			note_idx_reg <= 2'd0;
		end else begin
			if (st_reg == PS_NOTE && tx_ready)
				note_idx_reg <= 2'(note_idx_reg + 2'd1);
			else if (st_reg != PS_NOTE)
				note_idx_reg <= 2'd0;
			if (loop_done && mode_reg == CH_LOOP) begin
				loop_pend_reg <= 1'b1;
				loop_ext_reg <= loop_ext;
			end else if (st_reg == PS_NOTE && note_idx_reg == 2'd3 && tx_ready)
				loop_pend_reg <= 1'b0;
		end
	end
	// ****************************************
	// channel control
	// ****************************************
	logic exec;
	assign exec = st_reg == PS_RESP && !bad_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_reg <= CH_CLOSED;
			rate_reg <= `RATE_RESET;
			can_rate <= `RATE_RESET;
			can_enable <= 1'b0;
			can_silent <= 1'b0;
			can_loopback <= 1'b0;
			flush <= 1'b0;
			nv_wr <= 1'b0;
			nv_wr_rate <= 32'h0;
			frame_valid <= 1'b0;
			frame_id <= 29'h0;
			frame_ext <= 1'b0;
			frame_rtr <= 1'b0;
			frame_dlc <= 4'h0;
			frame_data <= 64'h0;
		end else begin
			flush <= 1'b0;
			nv_wr <= 1'b0;
			frame_valid <= 1'b0;
			if (nv_rate_valid && st_reg == PS_ID && !rx_strobe)
				rate_reg <= nv_rate;
			if (exec && cmd_reg == `CH_S) begin
				rate_reg <= rate_map(dec_reg);
				nv_wr_rate <= rate_map(dec_reg);
				nv_wr <= 1'b1;
			end
			if (exec && (cmd_reg == `CH_O || cmd_reg == `CH_L ||
				cmd_reg == `CH_LL)) begin
				// reopen is close then open: flush and new rate each time
				can_rate <= rate_reg;
				flush <= 1'b1;
				can_enable <= 1'b1;
				can_silent <= cmd_reg == `CH_L;
				can_loopback <= cmd_reg == `CH_LL;
				mode_reg <= cmd_reg == `CH_O ? CH_NORMAL :
					(cmd_reg == `CH_L ? CH_SILENT : CH_LOOP);
			end
			if (exec && cmd_reg == `CH_C) begin
				mode_reg <= CH_CLOSED;
				can_enable <= 1'b0;
				can_silent <= 1'b0;
				can_loopback <= 1'b0;
			end
			// queue-full is not seen here, so success stands regardless
			if (exec && is_frame && cnt_reg == need &&
				mode_reg != CH_CLOSED && mode_reg != CH_SILENT) begin
				frame_valid <= 1'b1;
				frame_id <= id_reg;
				frame_ext <= ext;
				frame_rtr <= rtr;
				frame_dlc <= dlc_reg;
				frame_data <= pay_reg << (7'd64 - 7'({dlc_reg, 3'b000}));
			end
		end
	end
endmodule // tunnel_cmd

// ===== sim/tunnel_cmd_props.sv
// assertions on the tunnel command parser ports
`include "tunnel_defs.svh"
module tunnel_cmd_props (
	input wire logic clk, // system clock
	input wire logic arst_n, // async reset
	input wire logic usb_host_present, // link select
	input wire logic [7:0] usb_tx_data, // usb byte
	input wire logic usb_tx_valid, // usb strobe
	input wire logic [7:0] uart_tx_data, // uart byte
	input wire logic uart_tx_valid, // uart strobe
	input wire logic can_enable, // controller on
	input wire logic can_silent, // listen only
	input wire logic flush, // clear pulse
	input wire logic [28:0] frame_id, // identifier
	input wire logic frame_ext, // long id
	input wire logic [3:0] frame_dlc, // length code
	input wire logic frame_valid // frame strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tx_any;
	logic [7:0] tx_byte;
	assign tx_any = usb_tx_valid | uart_tx_valid;
	assign tx_byte = usb_tx_valid ? usb_tx_data : uart_tx_data;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	AST_ONE_LINK: assert property (tx_any |-> usb_tx_valid == usb_host_present)
		else $error("reply on unselected link");
	AST_PRINTABLE: assert property (tx_any |-> tx_byte inside
		{[`CH_SP:`CH_TILDE], `CH_CR, `CH_BELL})
		else $error("unprintable byte sent");
	AST_FLUSH_OPEN: assert property (flush |-> can_enable)
		else $error("flush without open");
	AST_FLUSH_PULSE: assert property (flush |=> !flush)
		else $error("flush longer than one cycle");
	AST_SILENT_DROP: assert property (can_silent |-> !frame_valid)
		else $error("frame forwarded while silent");
	AST_SILENT_ON: assert property (can_silent |-> can_enable)
		else $error("silent while disabled");
	AST_FRAME_OPEN: assert property (frame_valid |-> can_enable)
		else $error("frame forwarded while closed");
	AST_DLC_MAX: assert property (frame_valid |-> frame_dlc <= `MAX_DLC)
		else $error("dlc above eight forwarded");
	AST_STD_ID: assert property (frame_valid && !frame_ext |-> frame_id[28:11] == 18'h0)
		else $error("short id overflows");
	AST_OFF_START: assert property ($rose(arst_n) |-> !can_enable)
		else $error("enabled after reset");
	AST_OPEN_ACK: assert property ($rose(can_enable) |-> ##[1:2] tx_any && tx_byte == `CH_CR)
		else $error("open not acknowledged");
endmodule // tunnel_cmd_props
bind tunnel_cmd tunnel_cmd_props i_props (.clk(clk), .arst_n(arst_n),
	.usb_host_present(usb_host_present), .usb_tx_data(usb_tx_data),
	.usb_tx_valid(usb_tx_valid), .uart_tx_data(uart_tx_data),
	.uart_tx_valid(uart_tx_valid), .can_enable(can_enable),
	.can_silent(can_silent), .flush(flush), .frame_id(frame_id),
	.frame_ext(frame_ext), .frame_dlc(frame_dlc), .frame_valid(frame_valid));

// ===== sim/tunnel_cmd_tb_top.sv
// self-checking bench for the tunnel command parser
module tunnel_cmd_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, arst_n, usb_host_present, tx_ready, flags_on;
	logic nv_rate_valid, loop_done, loop_ext, usb_rx_valid, uart_rx_valid;
	logic usb_tx_valid, uart_tx_valid, can_enable, can_silent, can_loopback;
	logic flush, frame_ext, frame_rtr, frame_valid, nv_wr;
	logic [7:0] usb_rx_data, uart_rx_data, usb_tx_data, uart_tx_data;
	logic [31:0] nv_rate, can_rate, nv_wr_rate, nv_cap;
	logic [28:0] frame_id, f_id;
	logic [3:0] frame_dlc, f_dlc;
	logic [63:0] frame_data, f_data;
	logic f_rtr;
	int f_cnt = 0;
	int fl_cnt = 0;
	int error_cnt = 0;
	int cmp_count = 0;
	tunnel_cmd i_tunnel_cmd (.*);
	tunnel_host i_tunnel_host (.*);
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (frame_valid) {f_id, f_dlc, f_data, f_rtr} =
			{frame_id, frame_dlc, frame_data, frame_rtr};
		if (frame_valid) f_cnt++;
		if (flush) fl_cnt++;
		if (nv_wr) nv_cap = nv_wr_rate;
	end
	// ****************
	// shared helpers
	// ****************
	task automatic check(input logic [63:0] s, input logic [63:0] e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, s, e);
		end
	endtask
	task automatic wait_rx(input int k);
		for (int n = 0; n < 300 && i_tunnel_host.rx_q.size() < k; n++)
			@(posedge clk);
	endtask
	task automatic cmd(input string s, input string e);
		i_tunnel_host.rx_q.delete();
		i_tunnel_host.send(s);
		wait_rx(e.len());
		repeat (4) @(posedge clk); // room for a stray extra byte
		foreach (e[i]) check(i_tunnel_host.rx_q[i], e[i]);
		check(i_tunnel_host.rx_q.size(), e.len());
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_open;
		check(can_enable, 0);
		check(can_rate, 32'h0007A120);
		cmd("O\r", "\r");
		check({can_enable, can_silent, can_loopback}, 3'h4);
		check(can_rate, 32'h0003D090);
		cmd("O\r", "\r");
		check(fl_cnt, 2);
		$display("open test done");
	endtask
	task automatic t_frames;
		cmd("t7FF0\r", "z\r");
		check({f_id, f_dlc}, {29'h7FF, 4'h0});
		check(frame_ext, 0);
		cmd("T1abcdEF02A5f0\r", "Z\r");
		check({f_id, f_dlc}, {29'h1ABCDEF0, 4'h2});
		check(frame_ext, 1);
		check(f_data, 64'hA5F0_0000_0000_0000);
		cmd("r1238\r", "z\r");
		check({f_rtr, f_id, f_dlc}, {1'h1, 29'h123, 4'h8});
		cmd("t7FF9\r", "\007");
		cmd("t7FF1\r", "\007");
		cmd("t7F0\r", "\007");
		cmd("t1230A\r", "\007");
		cmd("X\r", "\007");
		cmd("Mxy\r", "\r");
		cmd("m\r", "\r");
		check(f_cnt, 3);
		$display("frame test done");
	endtask
	task automatic t_rate;
		cmd("S4\r", "\r");
		check(nv_cap, 32'h0001E848);
		check(can_rate, 32'h0003D090);
		cmd("S1000\r", "\r");
		check(nv_cap, 32'h0000_03E8);
		cmd("L\r", "\r");
		check({can_silent, can_rate}, {1'h1, 32'h03E8});
		cmd("t1230\r", "z\r");
		check(f_cnt, 3);
		$display("rate test done");
	endtask
	task automatic t_loop;
		cmd("l\r", "\r");
		check({can_silent, can_loopback}, 2'h1);
		i_tunnel_host.rx_q.delete();
		i_tunnel_host.slow = 1;
		#1 loop_done = 1;
		@(posedge clk);
		#1 loop_done = 0;
		wait_rx(3);
		check({i_tunnel_host.rx_q[0], i_tunnel_host.rx_q[1]}, 16'h746C);
		check(i_tunnel_host.rx_q[2], 8'h0D);
		i_tunnel_host.slow = 0;
		// long id, flags off: no flag byte expected
		i_tunnel_host.rx_q.delete();
		#1 {flags_on, loop_ext, loop_done} = 3'h3;
		@(posedge clk);
		#1 loop_done = 0;
		wait_rx(2);
		repeat (4) @(posedge clk);
		check(i_tunnel_host.rx_q.size(), 2);
		check({i_tunnel_host.rx_q[0], i_tunnel_host.rx_q[1]}, 16'h540D);
		$display("loop test done");
	endtask
	task automatic t_close;
		cmd("C\r", "\r");
		check(can_enable, 0);
		cmd("C\r", "\r");
		cmd("t1230\r", "\007");
		check(f_cnt, 3);
		#1 usb_host_present = 1;
		cmd("O\r", "\r");
		check(i_tunnel_host.usb_n, 1);
		$display("close test done");
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		{arst_n, usb_host_present, flags_on, nv_rate_valid} = 4'h0;
		{loop_done, loop_ext, nv_rate} = 34'h0_0003_D090;
		repeat (3) @(posedge clk);
		#1 arst_n = 1;
		flags_on = 1;
		nv_rate_valid = 1; // restore happens only while valid and idle
		repeat (3) @(posedge clk);
		#1 nv_rate_valid = 0;
		t_open;
		t_frames;
		t_rate;
		t_loop;
		t_close;
		report_and_stop;
	end
	initial begin
		#100us;
		error_cnt++;
		report_and_stop;
	end
endmodule // tunnel_cmd_tb_top

// ===== sim/tunnel_host.sv
// host side model: sends command blocks, gathers reply bytes
module tunnel_host (
	input wire logic clk, // system clock
	input wire logic usb_host_present, // link select
	output logic [7:0] usb_rx_data, // byte to usb
	output logic usb_rx_valid, // usb strobe
	output logic [7:0] uart_rx_data, // byte to uart
	output logic uart_rx_valid, // uart strobe
	output logic tx_ready, // host takes bytes
	input wire logic [7:0] usb_tx_data, // usb reply
	input wire logic usb_tx_valid, // usb strobe
	input wire logic [7:0] uart_tx_data, // uart reply
	input wire logic uart_tx_valid // uart strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx_q[$];
	bit slow = 0;
	int usb_n = 0;
	int cyc = 0;
	initial begin
		{usb_rx_data, uart_rx_data} = 16'h0000;
		{usb_rx_valid, uart_rx_valid, tx_ready} = 3'h1;
	end
	always @(posedge clk) begin
		cyc++;
		if (usb_tx_valid) rx_q.push_back(usb_tx_data);
		if (usb_tx_valid) usb_n++;
		if (uart_tx_valid) rx_q.push_back(uart_tx_data);
		#1 tx_ready = !slow || cyc[1]; // stalls half the time when slow
	end
	// caller ends every block with cr, digits in either case
	task automatic send(input string s);
		logic [7:0] b;
		foreach (s[i]) begin
			b = s[i];
			@(posedge clk);
			#1;
			{usb_rx_data, uart_rx_data} = {b, b};
			usb_rx_valid = usb_host_present;
			uart_rx_valid = !usb_host_present;
		end
		@(posedge clk);
		#1;
		{usb_rx_valid, uart_rx_valid} = 2'h0;
		{usb_rx_data, uart_rx_data} = {~b, ~b}; // idle line not last value
	endtask
endmodule // tunnel_host
